// ===== jesd_tx_link_config.sv
// Link config registers and lane pattern generator.
// Avalon-MM slave for software access.
// Assumes link inputs synchronous to sys_clk
// and one lane octet per frame.
// Function
// - Test field picks normal, D21.5, K28.5, RPAT
// - Code 011: K28.5 then endless alignment sequence
// - Disparity flip acts only during RPAT
// - Frame assembly bits, upper resets one
// - Ramp replaces data in 12-bit packing
// - Alignment start delayed zero to three multiframes
// - Bit 7 enables payload scrambling, reset off
// - Frames per multiframe is field plus one
// - Override clear means five frames per multiframe
`timescale 1ns/1ns
module jesd_tx_link_config
	import jesd_tx_link_config_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [DATA_W-1:0] avs_writedata,
	input  wire logic [BE_W-1:0]   avs_byteenable,
	output logic      [DATA_W-1:0] avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              sync_n,
	input  wire logic              twelve_bit_packing,
	input  wire logic              sample_valid,
	output logic                   sample_ready,
	input  wire logic [7:0]        sample_octet,
	output logic                   lane_valid,
	input  wire logic              lane_ready,
	output logic      [7:0]        lane_octet,
	output logic                   lane_is_control,
	output logic                   lane_disparity_flip,
	output logic      [1:0]        frame_assembly_select,
	output logic      [2:0]        serializer_ratio_select,
	output logic                   scramble_enable,
	output logic      [5:0]        frames_per_multiframe,
	output logic                   multiframe_clock_mask_clear
);

	// Whole module state
	typedef struct packed {
		logic [REG_W-1:0] link_test_and_frame_select; // Test and frame fields
		logic [1:0]       alignment_sequence_delay;   // Multiframes of delay
		logic             scramble_en;                // Payload scrambling
		logic [4:0]       multiframe_length;          // K minus one
		logic [2:0]       serializer_ratio;           // Ratio field
		logic             override_en;                // Use programmed K
		logic             rd_done;                    // Read answer cycle
		logic [DATA_W-1:0] readdata;                  // Registered read data
		link_state_t      state;                      // Link sequencing
		logic [4:0]       frame_index;                // Position in multiframe
		logic [1:0]       delay_left;                 // Multiframes still to wait
		logic [1:0]       ila_mf;                     // Alignment multiframe
		logic [3:0]       rpat_index;                 // RPAT octet position
		logic [7:0]       ramp;                       // Ramp value
		logic [14:0]      scram;                      // Scrambler history
		logic             k28_5_sent;                 // Lead character done
	} state_t;

	state_t cur;   // Registered state
	state_t next_; // Next state

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [ADDR_W-1:0] idx);
		reg_addr = {idx[ADDR_W-3:0], 2'b00};
	endfunction : reg_addr

	// Scrambler 1 + x^14 + x^15, msb first
	function automatic logic [22:0] scramble_octet(input logic [14:0] hist,
	                                               input logic [7:0]  din);
		logic [14:0] h;
		logic [7:0]  dout;
		h    = hist;
		dout = '0;
		for (int i = 7; i >= 0; i--) begin
			dout[i] = din[i] ^ h[14] ^ h[13];
			h       = {h[13:0], dout[i]};
		end
		scramble_octet = {h, dout};
	endfunction : scramble_octet

	// Repeating 12-octet random pattern
	function automatic logic [7:0] rpat_octet(input logic [3:0] idx);
		case (idx)
			4'h0:    rpat_octet = 8'hbe;
			4'h1:    rpat_octet = 8'hd7;
			4'h2:    rpat_octet = 8'h23;
			4'h3:    rpat_octet = 8'h47;
			4'h4:    rpat_octet = 8'h6b;
			4'h5:    rpat_octet = 8'h8f;
			4'h6:    rpat_octet = 8'hb3;
			4'h7:    rpat_octet = 8'h14;
			4'h8:    rpat_octet = 8'h5e;
			4'h9:    rpat_octet = 8'hfb;
			4'ha:    rpat_octet = 8'h35;
			default: rpat_octet = 8'h59;
		endcase
	endfunction : rpat_octet

	// Decoded fields
	logic [2:0] test_sel;   // Link test pattern select
	logic [5:0] k_frames;   // Frames per multiframe in use
	logic       last_frame; // Multiframe boundary octet
	logic       ramp_mode;  // Ramp replaces samples

	assign test_sel  = cur.link_test_and_frame_select[LTP_HI:LTP_LO];
	assign ramp_mode = cur.link_test_and_frame_select[RAMP_EN_B]
	                   & twelve_bit_packing;
	// K under override, else five
	assign k_frames  = cur.override_en ? ({1'b0, cur.multiframe_length} + 6'h01)
	                                   : DEFAULT_FRAMES;
	// Wrap catches K shrinking
	assign last_frame = ({1'b0, cur.frame_index} >= (k_frames - 6'h01));

	// Configuration outputs
	assign frame_assembly_select = {cur.link_test_and_frame_select[FA_HI_B],
	                                cur.link_test_and_frame_select[FA_LO_B]};
	assign serializer_ratio_select     = cur.serializer_ratio;
	assign scramble_enable             = cur.scramble_en;
	assign frames_per_multiframe       = k_frames;
	assign multiframe_clock_mask_clear = cur.link_test_and_frame_select[MASK_CLR_B];

	// Generator to buffer handshake
	logic              gen_valid;  // Octet offered
	logic              gen_ready;  // Buffer has room
	logic              advance;    // Octet taken this cycle
	logic [7:0]        gen_octet;  // Octet content
	logic              gen_k;      // Control character flag
	logic              gen_flip;   // Disparity change request
	logic [7:0]        ila_octet;  // Alignment sequence octet
	logic              ila_k;      // Alignment octet is control
	logic [22:0]       scram_out;  // Scrambler history and octet

	assign advance   = gen_valid & gen_ready;
	assign scram_out = scramble_octet(cur.scram, sample_octet);
	// Samples drain only in payload
	assign sample_ready = gen_ready & (test_sel == TP_NORMAL)
	                      & (cur.state == ST_DATA) & ~ramp_mode;

	// Alignment octets: K28.0, K28.3, K28.4
	always_comb begin
		ila_octet = {3'h0, cur.frame_index};
		ila_k     = 1'b0;
		if (last_frame) begin
			ila_octet = CH_K28_3;
			ila_k     = 1'b1;
		end else if (cur.frame_index == 5'h00) begin
			ila_octet = CH_K28_0;
			ila_k     = 1'b1;
		end else if ((cur.ila_mf == 2'h1) && (cur.frame_index == 5'h01)) begin
			ila_octet = CH_K28_4;
			ila_k     = 1'b1;
		end
	end

	// Lane content selection
	always_comb begin
		gen_valid = 1'b1;
		gen_octet = CH_K28_5;
		gen_k     = 1'b1;
		gen_flip  = 1'b0;
		case (test_sel)
			TP_D21_5: begin
				gen_octet = CH_D21_5;
				gen_k     = 1'b0;
			end
			TP_K28_5: begin
				gen_octet = CH_K28_5;
			end
			TP_RPAT: begin
				gen_octet = rpat_octet(cur.rpat_index);
				gen_k     = 1'b0;
				gen_flip  = cur.link_test_and_frame_select[RPAT_FLIP_B];
			end
			TP_REPEAT_ILA: begin
				// One K28.5, then alignment forever
				if (cur.k28_5_sent) begin
					gen_octet = ila_octet;
					gen_k     = ila_k;
				end
			end
			default: begin
				// Normal data, also unused codes
				case (cur.state)
					ST_ILA: begin
						gen_octet = ila_octet;
						gen_k     = ila_k;
					end
					ST_DATA: begin
						gen_k = 1'b0;
						if (ramp_mode) begin
							gen_octet = cur.ramp;
						end else if (cur.scramble_en) begin
							gen_octet = scram_out[7:0];
							gen_valid = sample_valid;
						end else begin
							gen_octet = sample_octet;
							gen_valid = sample_valid;
						end
					end
					default: begin
						// Sync and delay send K28.5
						gen_octet = CH_K28_5;
					end
				endcase
			end
		endcase
	end

	// Registers and link sequencing
	always_comb begin
		next_ = cur;

		// Read answers one cycle late
		next_.rd_done = avs_read & ~cur.rd_done;
		if (avs_read & ~cur.rd_done) begin
			next_.readdata = '0;
			case (avs_address)
				reg_addr(IDX_LINK_TEST_AND_FRAME_SELECT):
					next_.readdata[REG_W-1:0] = cur.link_test_and_frame_select;
				reg_addr(IDX_ALIGNMENT_DELAY_CONTROL):
					next_.readdata[1:0] = cur.alignment_sequence_delay;
				reg_addr(IDX_SCRAMBLER_CONTROL):
					next_.readdata[SCRAMBLE_B] = cur.scramble_en;
				reg_addr(IDX_MULTIFRAME_LENGTH_CONTROL):
					next_.readdata[MF_LEN_HI:0] = cur.multiframe_length;
				reg_addr(IDX_SERIALIZER_RATIO_CONTROL):
					next_.readdata[SER_HI:SER_LO] = cur.serializer_ratio;
				reg_addr(IDX_LINK_OVERRIDE_CONTROL):
					next_.readdata[OVR_EN_B] = cur.override_en;
				reg_addr(IDX_LINK_STATUS):
					next_.readdata[REG_W-1:0] = {cur.frame_index, sync_n, cur.state};
				default: begin
					// Unmapped reads as zero
					next_.readdata = '0;
				end
			endcase
		end

		// Writes never wait; low byte only
		if (avs_write && avs_byteenable[0]) begin
			case (avs_address)
				reg_addr(IDX_LINK_TEST_AND_FRAME_SELECT):
					next_.link_test_and_frame_select = avs_writedata[REG_W-1:0];
				reg_addr(IDX_ALIGNMENT_DELAY_CONTROL):
					next_.alignment_sequence_delay = avs_writedata[1:0];
				reg_addr(IDX_SCRAMBLER_CONTROL):
					next_.scramble_en = avs_writedata[SCRAMBLE_B];
				reg_addr(IDX_MULTIFRAME_LENGTH_CONTROL):
					next_.multiframe_length = avs_writedata[MF_LEN_HI:0];
				reg_addr(IDX_SERIALIZER_RATIO_CONTROL):
					next_.serializer_ratio = avs_writedata[SER_HI:SER_LO];
				reg_addr(IDX_LINK_OVERRIDE_CONTROL):
					next_.override_en = avs_writedata[OVR_EN_B];
				default: begin
					// Status and unmapped ignore writes
					next_.override_en = cur.override_en;
				end
			endcase
		end

		// Lead character rearms off repeat mode
		if (test_sel != TP_REPEAT_ILA) begin
			next_.k28_5_sent = 1'b0;
		end

		// Timing moves with octets taken
		if (advance) begin
			next_.frame_index = last_frame ? 5'h00 : (cur.frame_index + 5'h01);
			next_.ramp        = cur.ramp + 8'h01;
			next_.rpat_index  = (cur.rpat_index >= RPAT_LAST) ? 4'h0
			                    : (cur.rpat_index + 4'h1);
			if ((test_sel == TP_NORMAL) && (cur.state == ST_DATA)
			    && cur.scramble_en && !ramp_mode) begin
				next_.scram = scram_out[22:8];
			end
			if (test_sel == TP_REPEAT_ILA) begin
				next_.k28_5_sent = 1'b1;
				if (cur.k28_5_sent && last_frame) begin
					next_.ila_mf = cur.ila_mf + 2'h1;
				end
			end
		end

		// Link sequencing in normal data mode
		if (test_sel == TP_NORMAL) begin
			case (cur.state)
				ST_CGS: begin
					// Leave sync at multiframe end
					if (advance && sync_n && last_frame) begin
						next_.ila_mf     = 2'h0;
						next_.delay_left = cur.alignment_sequence_delay;
						next_.state      = (cur.alignment_sequence_delay == 2'h0)
						                   ? ST_ILA : ST_DELAY;
					end
				end
				ST_DELAY: begin
					// Multiframes of K28.5 first
					if (advance && last_frame) begin
						next_.delay_left = cur.delay_left - 2'h1;
						if (cur.delay_left == 2'h1) begin
							next_.state = ST_ILA;
						end
					end
				end
				ST_ILA: begin
					if (advance && last_frame) begin
						next_.ila_mf = cur.ila_mf + 2'h1;
						if (cur.ila_mf == ILA_LAST_MF) begin
							next_.state = ST_DATA;
						end
					end
				end
				ST_DATA: begin
					next_.state = ST_DATA;
				end
				default: begin
					next_.state = ST_CGS;
				end
			endcase
			// Resync request wins
			if (!sync_n) begin
				next_.state = ST_CGS;
			end
		end else begin
			// Test patterns restart sequencing
			next_.state = ST_CGS;
		end
	end

	// State register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cur                            <= '0;
			cur.link_test_and_frame_select <= RST_LINK_TEST_AND_FRAME_SELECT;
			cur.alignment_sequence_delay   <= RST_ALIGNMENT_DELAY;
			cur.multiframe_length          <= RST_MULTIFRAME_LENGTH;
			cur.serializer_ratio           <= RST_SERIALIZER_RATIO;
			cur.state                      <= ST_CGS;
			cur.scram                      <= SCRAM_SEED;
		end else begin
			cur <= next_;
		end
	end

	// Read waits one cycle, writes none
	assign avs_waitrequest = avs_read & ~cur.rd_done;
	assign avs_readdata    = cur.readdata;

	// Stall by receiver loses nothing
	logic [LANE_W-1:0] lane_word; // Buffered octet and flags

	lane_skid_buffer #(
		.WIDTH (LANE_W)
	) u_lane_buffer (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_valid  (gen_valid),
		.in_ready  (gen_ready),
		.in_data   ({gen_flip, gen_k, gen_octet}),
		.out_valid (lane_valid),
		.out_ready (lane_ready),
		.out_data  (lane_word)
	);

	assign lane_octet          = lane_word[7:0];
	assign lane_is_control     = lane_word[8];
	assign lane_disparity_flip = lane_word[9];

endmodule : jesd_tx_link_config

// ===== jesd_tx_link_config_pkg.sv
// Constants, register map and link states.
// Assumes 32-bit Avalon-MM, one word per register.
package jesd_tx_link_config_pkg;

	// Bus geometry
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned BE_W     = 4;
	localparam int unsigned REG_W    = 8;
	localparam int unsigned LANE_W   = 10;  // Octet, control flag, disparity flip

	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_LINK_TEST_AND_FRAME_SELECT = 8'h03;
	localparam logic [ADDR_W-1:0] IDX_ALIGNMENT_DELAY_CONTROL    = 8'h04;
	localparam logic [ADDR_W-1:0] IDX_SCRAMBLER_CONTROL          = 8'h06;
	localparam logic [ADDR_W-1:0] IDX_MULTIFRAME_LENGTH_CONTROL  = 8'h07;
	localparam logic [ADDR_W-1:0] IDX_SERIALIZER_RATIO_CONTROL   = 8'h16;
	localparam logic [ADDR_W-1:0] IDX_LINK_OVERRIDE_CONTROL      = 8'h20;
	localparam logic [ADDR_W-1:0] IDX_LINK_STATUS                = 8'h21;

	// Reset values
	localparam logic [REG_W-1:0] RST_LINK_TEST_AND_FRAME_SELECT = 8'h04;
	localparam logic [1:0]       RST_ALIGNMENT_DELAY            = 2'h0;
	localparam logic [4:0]       RST_MULTIFRAME_LENGTH          = 5'h00;
	localparam logic [2:0]       RST_SERIALIZER_RATIO           = 3'h0;

	// Field positions
	localparam int unsigned LTP_HI      = 7;  // Link test pattern select, 7:5
	localparam int unsigned LTP_LO      = 5;
	localparam int unsigned RPAT_FLIP_B = 4;
	localparam int unsigned MASK_CLR_B  = 3;
	localparam int unsigned FA_HI_B     = 2;
	localparam int unsigned FA_LO_B     = 1;
	localparam int unsigned RAMP_EN_B   = 0;
	localparam int unsigned SCRAMBLE_B  = 7;
	localparam int unsigned MF_LEN_HI   = 4;
	localparam int unsigned SER_HI      = 6;
	localparam int unsigned SER_LO      = 4;
	localparam int unsigned OVR_EN_B    = 0;

	// Link test pattern codes
	localparam logic [2:0] TP_NORMAL     = 3'h0;
	localparam logic [2:0] TP_D21_5      = 3'h1;
	localparam logic [2:0] TP_K28_5      = 3'h2;
	localparam logic [2:0] TP_REPEAT_ILA = 3'h3;
	localparam logic [2:0] TP_RPAT       = 3'h4;

	// Characters
	localparam logic [7:0] CH_D21_5 = 8'hb5;
	localparam logic [7:0] CH_K28_5 = 8'hbc;
	localparam logic [7:0] CH_K28_0 = 8'h1c;
	localparam logic [7:0] CH_K28_3 = 8'h7c;
	localparam logic [7:0] CH_K28_4 = 8'h9c;

	// Multiframe and alignment figures
	localparam logic [5:0] DEFAULT_FRAMES = 6'h05;
	localparam logic [1:0] ILA_LAST_MF    = 2'h3;
	localparam logic [3:0] RPAT_LAST      = 4'hb;
	localparam logic [14:0] SCRAM_SEED    = 15'h7fff;

	// Link sequencing states, Gray ordered
	typedef enum logic [1:0] {
		ST_CGS   = 2'b00,
		ST_DELAY = 2'b01,
		ST_ILA   = 2'b11,
		ST_DATA  = 2'b10
	} link_state_t;

endpackage : jesd_tx_link_config_pkg

// ===== jesd_tx_link_config_props.sv
// Checker bound to the link config ports.
// Assumes one clock and active-high async reset.
`timescale 1ns/1ns
module jesd_tx_link_config_props
	import jesd_tx_link_config_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [DATA_W-1:0] avs_writedata,
	input wire logic [BE_W-1:0]   avs_byteenable,
	input wire logic              avs_waitrequest,
	input wire logic              lane_valid,
	input wire logic              lane_ready,
	input wire logic [7:0]        lane_octet,
	input wire logic              lane_is_control,
	input wire logic              lane_disparity_flip,
	input wire logic [1:0]        frame_assembly_select,
	input wire logic [2:0]        serializer_ratio_select,
	input wire logic              scramble_enable,
	input wire logic [5:0]        frames_per_multiframe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic       wr_ok; // Write that really lands
	logic [2:0] tp;    // Shadow test code
	logic [2:0] age;   // Handshakes since code write
	logic [1:0] fa;    // Shadow frame assembly bits
	logic       scr;   // Shadow scrambler bit
	logic       ovr;   // Shadow override bit
	logic [2:0] rat;   // Shadow ratio field
	logic [4:0] kf;    // Shadow multiframe field

	assign wr_ok = avs_write && avs_byteenable[0];

	// Shadows; age lets old octets drain
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{tp, age, scr, ovr, rat, kf} <= '0;
			fa <= 2'b10;
		end else begin
			if (lane_valid && lane_ready && age != 3'h7)
				age <= age + 3'h1;
			if (wr_ok) begin
				case (avs_address)
					8'h0c: begin
						tp  <= avs_writedata[7:5];
						fa  <= avs_writedata[2:1];
						age <= 3'h0;
					end
					8'h18: scr <= avs_writedata[7];
					8'h1c: kf <= avs_writedata[4:0];
					8'h58: rat <= avs_writedata[6:4];
					8'h80: ovr <= avs_writedata[0];
					default: ;
				endcase
			end
		end
	end

	property p_read_wait;
		$rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait not one cycle");
	property p_write_nowait;
		avs_write |-> !avs_waitrequest;
	endproperty
	a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
	property p_fa;
		frame_assembly_select == fa;
	endproperty
	a_fa: assert property (p_fa) else $error("fa wrong");
	property p_scramble;
		scramble_enable == scr;
	endproperty
	a_scramble: assert property (p_scramble) else $error("scramble enable wrong");
	property p_ratio;
		serializer_ratio_select == rat;
	endproperty
	a_ratio: assert property (p_ratio) else $error("ratio field wrong");
	property p_frames;
		frames_per_multiframe == (ovr ? {1'b0, kf} + 6'h01 : DEFAULT_FRAMES);
	endproperty
	a_frames: assert property (p_frames) else $error("K wrong");
	property p_lane_hold;
		lane_valid && !lane_ready |=> lane_valid && $stable(lane_octet)
			&& $stable(lane_is_control) && $stable(lane_disparity_flip);
	endproperty
	a_lane_hold: assert property (p_lane_hold) else $error("lane changed in stall");
	property p_d21;
		tp == TP_D21_5 && age == 3'h7 && lane_valid |-> lane_octet == CH_D21_5 && !lane_is_control;
	endproperty
	a_d21: assert property (p_d21) else $error("D21.5 wrong");
	property p_k28;
		tp == TP_K28_5 && age == 3'h7 && lane_valid |-> lane_octet == CH_K28_5 && lane_is_control;
	endproperty
	a_k28: assert property (p_k28) else $error("K28.5 wrong");
	property p_flip_rpat;
		tp != TP_RPAT && age == 3'h7 && lane_valid |-> !lane_disparity_flip;
	endproperty
	a_flip_rpat: assert property (p_flip_rpat) else $error("stray flip");

	c_read: cover property (avs_read && !avs_waitrequest);
	c_stall: cover property (lane_valid && !lane_ready ##1 lane_valid && lane_ready);
	c_flip: cover property (lane_valid && lane_disparity_flip);
endmodule : jesd_tx_link_config_props

bind jesd_tx_link_config jesd_tx_link_config_props u_props (
	.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest), .lane_valid(lane_valid), .lane_ready(lane_ready),
	.lane_octet(lane_octet), .lane_is_control(lane_is_control),
	.lane_disparity_flip(lane_disparity_flip), .frame_assembly_select(frame_assembly_select),
	.serializer_ratio_select(serializer_ratio_select), .scramble_enable(scramble_enable),
	.frames_per_multiframe(frames_per_multiframe)
);

// ===== lane_rx_model.sv
// Model of the downstream lane receiver: ready and sync request.
// Assumes the bench times the sync release.
`timescale 1ns/1ns
module lane_rx_model (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic sync_release,
	input  wire logic slow,
	output logic      lane_ready,
	output logic      sync_n
);
	logic [1:0] cnt; // Stall pacing

	// Slow takes one word in four; buffer fills
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt        <= 2'h0;
			lane_ready <= 1'b0;
			sync_n     <= 1'b0;
		end else begin
			cnt        <= cnt + 2'h1;
			lane_ready <= !slow || cnt == 2'h0;
			sync_n     <= sync_release;
		end
	end
endmodule : lane_rx_model

// ===== lane_skid_buffer.sv
// Two-entry lane buffer.
// Assumes the drain may stall at any time.
`timescale 1ns/1ns
module lane_skid_buffer
	import jesd_tx_link_config_pkg::*;
#(
	parameter int unsigned WIDTH = LANE_W
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	// Whole buffer state
	typedef struct packed {
		logic [1:0][WIDTH-1:0] mem;    // Two storage words
		logic                  wr_ptr; // Next slot to fill
		logic                  rd_ptr; // Oldest slot
		logic [1:0]            count;  // Words held
	} buf_t;

	buf_t cur;   // Registered state
	buf_t next_; // Next state
	logic push;  // Word accepted
	logic pop;   // Word drained

	// Flags from the count
	assign in_ready  = (cur.count != 2'h2);
	assign out_valid = (cur.count != 2'h0);
	assign out_data  = cur.mem[cur.rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointer and count update
	always_comb begin
		next_ = cur;
		if (push) begin
			next_.mem[cur.wr_ptr] = in_data;
			next_.wr_ptr          = ~cur.wr_ptr;
		end
		if (pop) begin
			next_.rd_ptr = ~cur.rd_ptr;
		end
		case ({push, pop})
			2'b10:   next_.count = cur.count + 2'h1;
			2'b01:   next_.count = cur.count - 2'h1;
			default: next_.count = cur.count;
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_;
		end
	end

endmodule : lane_skid_buffer

// ===== tb_top.sv
// Testbench for the link configuration block.
// Assumes the receiver model and bound checker.
`timescale 1ns/1ns
module tb_top
	import jesd_tx_link_config_pkg::*;
;
	localparam logic [7:0] adr[6] = '{8'h0c, 8'h10, 8'h18, 8'h1c, 8'h58, 8'h80};
	localparam logic [7:0] msk[6] = '{8'hff, 8'h03, 8'h80, 8'h1f, 8'h70, 8'h01};
	localparam logic [7:0] rp[12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
		8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};

	logic              sys_clk = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] avs_address = '0;
	logic              avs_read = 1'b0;
	logic              avs_write = 1'b0;
	logic [DATA_W-1:0] avs_writedata = '0;
	logic [BE_W-1:0]   avs_byteenable = '0;
	logic [DATA_W-1:0] avs_readdata;
	logic              avs_waitrequest;
	logic              sample_valid = 1'b0;
	logic [7:0]        sample_octet = '0;
	logic              sync_n, lane_valid, lane_ready, lane_is_control, lane_disparity_flip;
	logic [7:0]        lane_octet;
	logic              sync_release = 1'b0; // Link may leave sync
	logic              slow = 1'b0;         // Receiver stalls
	logic [31:0]       seed = 32'h8a63;
	logic [31:0]       d;
	logic [31:0]       rq[$];  // Expected read data
	logic [9:0]        lq[$];  // Expected octet, control, flip
	logic [7:0]        pat[12];
	int                errors = 0, checked = 0, hs = 0, cyc = 0, k0 = 0, k5 = 0, c, nb, n1;

	always #2 sys_clk = ~sys_clk;

	jesd_tx_link_config u_dut (
		.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .sync_n(sync_n), .twelve_bit_packing(1'b0),
		.sample_valid(sample_valid), .sample_ready(), .sample_octet(sample_octet),
		.lane_valid(lane_valid), .lane_ready(lane_ready), .lane_octet(lane_octet),
		.lane_is_control(lane_is_control), .lane_disparity_flip(lane_disparity_flip),
		.frame_assembly_select(), .serializer_ratio_select(), .scramble_enable(),
		.frames_per_multiframe(), .multiframe_clock_mask_clear()
	);

	lane_rx_model u_rx (
		.sys_clk(sys_clk), .rst(rst), .sync_release(sync_release), .slow(slow),
		.lane_ready(lane_ready), .sync_n(sync_n)
	);

	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task close_out;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	// Request held until waitrequest low at an edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] be);
		@(posedge sys_clk);
		avs_write      <= w;
		avs_read       <= !w;
		avs_address    <= a;
		avs_writedata  <= v;
		avs_byteenable <= be;
		@(negedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(negedge sys_clk);
		@(posedge sys_clk);
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] be);
		bus(1'b1, a, v, be);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, 32'h0, 4'hf);
	endtask : rd

	task wait_hs(input int n);
		n1 = hs + n;
		while (hs < n1) @(posedge sys_clk);
	endtask : wait_hs

	// Lock on pattern start, note one period
	task follow(input logic [7:0] rv, input logic ctl);
		wr(8'h0c, {24'h0, rv}, 4'h1);
		wait_hs(8);
		@(negedge sys_clk);
		n1 = 0;
		while (!(lane_valid && lane_ready && lane_octet == pat[0]) && n1 < 100) begin
			@(negedge sys_clk);
			n1++;
		end
		@(posedge sys_clk);
		for (int i = 1; i < 13; i++) lq.push_back({pat[i % 12], ctl, rv[4]});
		wait_hs(12);
		chk("lane_left", 32'h0, lq.size());
		lq.delete();
		$display("test pattern %h done", rv);
	endtask : follow

	// Random sample stream into the data path
	always @(posedge sys_clk) {sample_valid, sample_octet} <= 9'(xs());

	// Watcher: oldest note against outputs, mid-cycle
	always @(negedge sys_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rq.size() > 0)
			chk("readdata", rq.pop_front(), avs_readdata);
		if (lane_valid === 1'b1 && lane_ready === 1'b1) begin
			hs++;
			k0 += (lane_octet === CH_K28_0);
			k5 += (lane_octet === CH_K28_5);
			if (lq.size() > 0)
				chk("lane", {22'h0, lq.pop_front()},
					{22'h0, lane_octet, lane_is_control, lane_disparity_flip});
		end
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			close_out();
		end
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h0c, 32'h04);
		for (int i = 1; i < 6; i++) rd(adr[i], 32'h0);
		rd(8'h40, 32'h0);
		$display("test reset_values done");
		foreach (adr[i]) begin
			d = xs();
			if (i == 4) d[6:4] = {3{d[6]}};
			wr(adr[i], d, 4'h1);
			rd(adr[i], d & {24'h0, msk[i]});
		end
		wr(8'h1c, 32'h03, 4'h1);
		wr(8'h1c, 32'h1f, 4'he);
		rd(8'h1c, 32'h03);
		wr(8'h40, 32'hff, 4'h1);
		rd(8'h40, 32'h0);
		$display("test readback done");
		wr(8'h0c, 32'h04, 4'h1);
		wr(8'h80, 32'h01, 4'h1);
		wr(8'h1c, 32'h07, 4'h1);
		wr(8'h58, 32'h70, 4'h1);
		wr(8'h18, 32'h00, 4'h1);
		for (int dl = 0; dl < 4; dl++) begin
			sync_release <= 1'b0;
			wr(8'h10, dl, 4'h1);
			repeat (30) @(posedge sys_clk);
			sync_release <= 1'b1;
			c = hs;
			n1 = k0;
			repeat (400) if (k0 == n1) @(posedge sys_clk);
			c = hs - c;
			chk("ila_start", 32'h1, 32'(c > dl * 8 && c <= dl * 8 + 14));
		end
		$display("test alignment_delay done");
		foreach (pat[i]) pat[i] = CH_D21_5;
		follow(8'h24, 1'b0);
		foreach (pat[i]) pat[i] = CH_K28_5;
		follow(8'h44, 1'b1);
		pat = rp;
		slow <= 1'b1;
		follow(8'h84, 1'b0);
		follow(8'h94, 1'b0);
		slow <= 1'b0;
		wr(8'h0c, 32'h64, 4'h1);
		wait_hs(8);
		c = k0;
		nb = k5;
		wait_hs(64);
		chk("ila_repeat", 32'h1, 32'(k0 - c >= 7 && k5 == nb));
		$display("test repeat_alignment done");
		close_out();
	end
endmodule : tb_top
